// >>> verilog/dlk_pkg.sv
// Package for the debug link key session block: register map, fields, keys, codes.
// Assumes an 8-bit control-space register port driven by the link access layer.
package dlk_pkg;

  // Register offsets (control space)
  localparam logic [3:0] DLK_REG_REV      = 4'h0;
  localparam logic [3:0] DLK_REG_ERR      = 4'h1;
  localparam logic [3:0] DLK_REG_PHY      = 4'h2;
  localparam logic [3:0] DLK_REG_EN       = 4'h3;
  localparam logic [3:0] DLK_REG_KEY      = 4'h7;
  localparam logic [3:0] DLK_REG_RST      = 4'h8;
  localparam logic [3:0] DLK_REG_CLKDIV   = 4'h9;
  localparam logic [3:0] DLK_REG_SYSCTL   = 4'hA;
  localparam logic [3:0] DLK_REG_SYSSTAT  = 4'hB;
  localparam logic [3:0] DLK_REG_BOOTCHK  = 4'hC;

  // Reset values
  localparam logic [7:0] DLK_REV_VALUE    = 8'h10;
  localparam logic [7:0] DLK_ZERO         = 8'h00;
  localparam logic [1:0] DLK_CLKDIV_RST   = 2'h3;

  // Key status fields
  localparam int DLK_KEY_ROW_BIT   = 5;
  localparam int DLK_KEY_PROG_BIT  = 4;
  localparam int DLK_KEY_ERASE_BIT = 3;

  // Enable control fields
  localparam int DLK_EN_DISABLE_BIT = 2;

  // System control fields
  localparam int DLK_SYS_DONE_BIT  = 1;
  localparam int DLK_SYS_CREQ_BIT  = 0;

  // System status fields
  localparam int DLK_ST_FAIL_BIT   = 6;
  localparam int DLK_ST_RST_BIT    = 5;
  localparam int DLK_ST_SLEEP_BIT  = 4;
  localparam int DLK_ST_PROG_BIT   = 3;
  localparam int DLK_ST_ROW_BIT    = 2;
  localparam int DLK_ST_BOOT_BIT   = 1;
  localparam int DLK_ST_LOCK_BIT   = 0;

  // Reset request codes
  localparam logic [7:0] DLK_RST_ASSERT  = 8'h59;
  localparam logic [7:0] DLK_RST_RELEASE = 8'h00;

  // Session keys, shifted in least significant byte first
  localparam logic [63:0] DLK_KEY_ERASE = 64'h4E564D4572617365;
  localparam logic [63:0] DLK_KEY_PROG  = 64'h4E564D50726F6720;
  localparam logic [63:0] DLK_KEY_ROW   = 64'h4E564D5573267465;

  // User row buffer window
  localparam logic [15:0] DLK_ROW_BYTES = 16'h0020;

  // Session sequencer states
  typedef enum logic [2:0] {
    DLK_IDLE      = 3'b000,
    DLK_IN_RESET  = 3'b001,
    DLK_ERASING   = 3'b010,
    DLK_PROG_OPEN = 3'b011,
    DLK_ROW_FILL  = 3'b100,
    DLK_ROW_BURN  = 3'b101
  } dlk_state_t;

endpackage

// >>> verilog/dlk_key_shift.sv
// Key shifter: collects 64-bit key bytes, LSB first, and matches against the session keys.
// Assumes one strobe per key byte and a start strobe before the first byte.
`timescale 1ns/1ps
module dlk_key_shift
  import dlk_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       clear,
  input  wire logic       key_start,
  input  wire logic       key_byte_vld,
  input  wire logic [7:0] key_byte,
  output logic            hit_erase,
  output logic            hit_prog,
  output logic            hit_row
);

  logic [63:0] shift_ff;
  logic [63:0] nxt_shift;
  logic [3:0]  cnt_ff;
  logic [3:0]  nxt_cnt;
  logic        done_ff;
  logic        nxt_done;

  always_comb begin
    nxt_shift = shift_ff;
    nxt_cnt   = cnt_ff;
    nxt_done  = 1'b0;
    if (clear || key_start) begin
      nxt_cnt = 4'h0;
    end else if (key_byte_vld) begin
      // First byte ends up lowest after eight shifts
      nxt_shift = {key_byte, shift_ff[63:8]};
      nxt_cnt   = cnt_ff + 4'h1;
      nxt_done  = (cnt_ff == 4'h7);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_ff <= 64'h0;
      cnt_ff   <= 4'h0;
      done_ff  <= 1'b0;
    end else begin
      shift_ff <= nxt_shift;
      cnt_ff   <= nxt_cnt;
      done_ff  <= nxt_done;
    end
  end

  // One-cycle match pulses after the eighth byte
  assign hit_erase = done_ff && (shift_ff == DLK_KEY_ERASE);
  assign hit_prog  = done_ff && (shift_ff == DLK_KEY_PROG);
  assign hit_row   = done_ff && (shift_ff == DLK_KEY_ROW);

endmodule // dlk_key_shift

// >>> verilog/dlk_session.sv
// Debug link access-layer session control: keys, reset request, lock, erase, row buffer.
// Assumes control-space accesses arrive as single-cycle strobes from the link layer,
// and that the nonvolatile controller answers erase and row programming with done pulses.
//
// Overview of operation
// - After reset request, writing zero releases the system reset.
// - Erase outcome shows in erase-failed bit; zero means success.
// - Successful erase clears lock; locked link refuses system bus access except row-mode buffer writes.
// - Brown-out detector forced active during erase.
// - Row mode accepts RAM writes to first 32 bytes only.
// - Row done starts programming; device clears row start when finished.
// - Row mode returns no RAM contents on reads.
// - Every sync rising edge gives a level event; cannot be disabled.
// - Link stays reachable in sleep; bus unreachable when clock stops.
// - In-sleep status bit shows system domain sleeping only while clock request is clear.
// - Clock request keeps clock in sleep, allows bus; defaults one.
// - Keys are 64-bit values sent least significant byte first.
// - Code 0x59 asserts system reset; 0x00 clears it; others reserved.
// - Requested system reset does not reset the link logic.
// - Key status bits set on decode; program key clears on start.
`timescale 1ns/1ps
module dlk_session
  import dlk_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Control-space register port
  input  wire logic        cs_wr,
  input  wire logic        cs_rd,
  input  wire logic [3:0]  cs_addr,
  input  wire logic [7:0]  cs_wdata,
  output logic [7:0]       cs_rdata,
  // Key instruction bytes
  input  wire logic        key_start,
  input  wire logic        key_byte_vld,
  input  wire logic [7:0]  key_byte,
  // Link layer status
  input  wire logic        sync_edge,
  input  wire logic [2:0]  link_err_code,
  input  wire logic        link_err_set,
  // System bus requests from the link
  input  wire logic        bus_req,
  input  wire logic        bus_we,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_is_ram,
  output logic             bus_grant,
  output logic             bus_write_ok,
  output logic             bus_read_blank,
  // System side
  input  wire logic        lock_bits_set,
  input  wire logic        system_sleeping,
  input  wire logic        system_clock_on,
  input  wire logic        boot_done,
  input  wire logic [2:0]  boot_check_code,
  input  wire logic        erase_done,
  input  wire logic        erase_fail,
  input  wire logic        row_prog_done,
  output logic             sys_reset_req,
  output logic             erase_start,
  output logic             row_prog_start,
  output logic             brownout_detector_force,
  output logic             system_clock_request,
  output logic             sync_edge_event,
  output logic [7:0]       link_phy_cfg,
  output logic [1:0]       link_clk_sel,
  output logic             link_disable
);

  dlk_state_t  st_ff, nxt_st;
  logic [7:0]  rst_req_ff, nxt_rst_req;
  logic [7:0]  phy_ff, nxt_phy;
  logic [7:0]  en_ff, nxt_en;
  logic [1:0]  clkdiv_ff, nxt_clkdiv;
  logic [2:0]  err_ff, nxt_err;
  logic        k_erase_ff, nxt_k_erase;
  logic        k_prog_ff, nxt_k_prog;
  logic        k_row_ff, nxt_k_row;
  logic        creq_ff, nxt_creq;
  logic        fail_ff, nxt_fail;
  logic        pstart_ff, nxt_pstart;
  logic        rstart_ff, nxt_rstart;
  logic        erase_go_ff, nxt_erase_go;
  logic        row_go_ff, nxt_row_go;
  logic        sync_ff, nxt_sync;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic        hit_erase, hit_prog, hit_row;
  logic        link_clear;
  logic        rst_active;

  function automatic logic wr_to(input logic [3:0] a);
    wr_to = cs_wr && (cs_addr == a);
  endfunction

  // Link disable drops keys and link settings; system reset never reaches here
  assign link_clear = en_ff[DLK_EN_DISABLE_BIT];
  assign rst_active = (rst_req_ff == DLK_RST_ASSERT);

  dlk_key_shift u_keys (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .clear        (link_clear),
    .key_start    (key_start),
    .key_byte_vld (key_byte_vld),
    .key_byte     (key_byte),
    .hit_erase    (hit_erase),
    .hit_prog     (hit_prog),
    .hit_row      (hit_row)
  );

  always_comb begin
    nxt_st       = st_ff;
    nxt_rst_req  = rst_req_ff;
    nxt_phy      = phy_ff;
    nxt_en       = en_ff;
    nxt_clkdiv   = clkdiv_ff;
    nxt_err      = err_ff;
    nxt_k_erase  = k_erase_ff;
    nxt_k_prog   = k_prog_ff;
    nxt_k_row    = k_row_ff;
    nxt_creq     = creq_ff;
    nxt_fail     = fail_ff;
    nxt_pstart   = pstart_ff;
    nxt_rstart   = rstart_ff;
    nxt_erase_go = 1'b0;
    nxt_row_go   = 1'b0;
    nxt_sync     = sync_edge;

    // Register writes; reserved reset codes are ignored
    if (wr_to(DLK_REG_RST) && (cs_wdata == DLK_RST_ASSERT ||
        cs_wdata == DLK_RST_RELEASE)) begin
      nxt_rst_req = cs_wdata;
    end
    if (wr_to(DLK_REG_PHY)) begin
      nxt_phy = cs_wdata;
    end
    if (wr_to(DLK_REG_EN)) begin
      nxt_en = cs_wdata;
    end
    if (wr_to(DLK_REG_CLKDIV)) begin
      nxt_clkdiv = cs_wdata[1:0];
    end
    if (wr_to(DLK_REG_SYSCTL)) begin
      nxt_creq = cs_wdata[DLK_SYS_CREQ_BIT];
    end
    // Error code clears on read, a new error wins
    if (cs_rd && cs_addr == DLK_REG_ERR) begin
      nxt_err = DLK_ZERO[2:0];
    end
    if (link_err_set) begin
      nxt_err = link_err_code;
    end

    // Key decode sets status; set wins over a row-bit key write clear, but session start and link disable clears win
    if (wr_to(DLK_REG_KEY) && cs_wdata[DLK_KEY_ROW_BIT]) begin
      nxt_k_row = 1'b0;
    end
    if (hit_erase) begin
      nxt_k_erase = 1'b1;
    end
    if (hit_prog) begin
      nxt_k_prog = 1'b1;
    end
    if (hit_row) begin
      nxt_k_row = 1'b1;
    end

    unique case (st_ff)
      DLK_IDLE: begin
        if (rst_active) begin
          nxt_st = DLK_IN_RESET;
        end
      end
      DLK_IN_RESET: begin
        // Session picked on reset release
        if (!rst_active) begin
          if (k_erase_ff) begin
            nxt_st       = DLK_ERASING;
            nxt_erase_go = 1'b1;
            nxt_k_erase  = 1'b0;
            nxt_fail     = 1'b0;
          end else if (k_prog_ff && !lock_bits_set) begin
            nxt_st     = DLK_PROG_OPEN;
            nxt_pstart = 1'b1;
            nxt_k_prog = 1'b0;
          end else if (k_row_ff) begin
            nxt_st     = DLK_ROW_FILL;
            nxt_rstart = 1'b1;
          end else begin
            nxt_st     = DLK_IDLE;
            nxt_pstart = 1'b0;
            nxt_rstart = 1'b0;
          end
        end
      end
      DLK_ERASING: begin
        if (erase_done) begin
          nxt_fail = erase_fail;
          nxt_st   = DLK_IDLE;
        end
      end
      DLK_PROG_OPEN, DLK_ROW_FILL: begin
        // Asserting reset closes the session
        if (rst_active) begin
          nxt_st = DLK_IN_RESET;
        end else if (st_ff == DLK_ROW_FILL && k_row_ff &&
                     wr_to(DLK_REG_SYSCTL) && cs_wdata[DLK_SYS_DONE_BIT]) begin
          nxt_st     = DLK_ROW_BURN;
          nxt_row_go = 1'b1;
        end
      end
      DLK_ROW_BURN: begin
        if (row_prog_done) begin
          nxt_rstart = 1'b0;
          nxt_st     = DLK_IDLE;
        end
      end
      default: nxt_st = DLK_IDLE;
    endcase

    // Link disable resets keys and link settings
    if (link_clear) begin
      nxt_k_erase = 1'b0;
      nxt_k_prog  = 1'b0;
      nxt_k_row   = 1'b0;
      nxt_phy     = DLK_ZERO;
      nxt_creq    = 1'b0;
      nxt_clkdiv  = DLK_CLKDIV_RST;
      if (wr_to(DLK_REG_EN)) begin
        nxt_en = cs_wdata;
      end
    end
  end

  always_comb begin
    nxt_rdata = DLK_ZERO;
    unique case (cs_addr)
      DLK_REG_REV:     nxt_rdata = DLK_REV_VALUE;
      DLK_REG_ERR:     nxt_rdata = {5'h00, err_ff};
      DLK_REG_PHY:     nxt_rdata = phy_ff;
      DLK_REG_EN:      nxt_rdata = en_ff;
      DLK_REG_KEY: begin
        nxt_rdata[DLK_KEY_ROW_BIT]   = k_row_ff;
        nxt_rdata[DLK_KEY_PROG_BIT]  = k_prog_ff;
        nxt_rdata[DLK_KEY_ERASE_BIT] = k_erase_ff;
      end
      DLK_REG_RST:     nxt_rdata = rst_req_ff;
      DLK_REG_CLKDIV:  nxt_rdata = {6'h00, clkdiv_ff};
      DLK_REG_SYSCTL:  nxt_rdata[DLK_SYS_CREQ_BIT] = creq_ff;
      DLK_REG_SYSSTAT: begin
        nxt_rdata[DLK_ST_FAIL_BIT]  = fail_ff;
        nxt_rdata[DLK_ST_RST_BIT]   = rst_active;
        nxt_rdata[DLK_ST_SLEEP_BIT] = system_sleeping && !creq_ff;
        nxt_rdata[DLK_ST_PROG_BIT]  = pstart_ff;
        nxt_rdata[DLK_ST_ROW_BIT]   = rstart_ff;
        nxt_rdata[DLK_ST_BOOT_BIT]  = boot_done;
        nxt_rdata[DLK_ST_LOCK_BIT]  = lock_bits_set;
      end
      DLK_REG_BOOTCHK: nxt_rdata = {5'h00, boot_check_code};
      default:         nxt_rdata = DLK_ZERO;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff       <= DLK_IDLE;
      rst_req_ff  <= DLK_RST_RELEASE;
      phy_ff      <= DLK_ZERO;
      en_ff       <= DLK_ZERO;
      clkdiv_ff   <= DLK_CLKDIV_RST;
      err_ff      <= 3'h0;
      k_erase_ff  <= 1'b0;
      k_prog_ff   <= 1'b0;
      k_row_ff    <= 1'b0;
      creq_ff     <= 1'b1;
      fail_ff     <= 1'b0;
      pstart_ff   <= 1'b0;
      rstart_ff   <= 1'b0;
      erase_go_ff <= 1'b0;
      row_go_ff   <= 1'b0;
      sync_ff     <= 1'b0;
      rdata_ff    <= DLK_ZERO;
    end else begin
      st_ff       <= nxt_st;
      rst_req_ff  <= nxt_rst_req;
      phy_ff      <= nxt_phy;
      en_ff       <= nxt_en;
      clkdiv_ff   <= nxt_clkdiv;
      err_ff      <= nxt_err;
      k_erase_ff  <= nxt_k_erase;
      k_prog_ff   <= nxt_k_prog;
      k_row_ff    <= nxt_k_row;
      creq_ff     <= nxt_creq;
      fail_ff     <= nxt_fail;
      pstart_ff   <= nxt_pstart;
      rstart_ff   <= nxt_rstart;
      erase_go_ff <= nxt_erase_go;
      row_go_ff   <= nxt_row_go;
      sync_ff     <= nxt_sync;
      rdata_ff    <= nxt_rdata;
    end
  end

  // Outputs
  assign cs_rdata                = rdata_ff;
  assign sys_reset_req           = rst_active;
  assign erase_start             = erase_go_ff;
  assign row_prog_start          = row_go_ff;
  assign brownout_detector_force = (st_ff == DLK_ERASING);
  assign system_clock_request    = creq_ff && !link_clear;
  assign sync_edge_event         = sync_ff;
  assign link_phy_cfg            = phy_ff;
  assign link_clk_sel            = clkdiv_ff;
  assign link_disable            = link_clear;

  // Bus needs clock and unlocked part; row mode RAM accesses only see the buffer window
  always_comb begin
    bus_grant      = bus_req && !lock_bits_set && (system_clock_on || system_clock_request);
    bus_write_ok   = 1'b0;
    bus_read_blank = 1'b0;
    if (st_ff == DLK_ROW_FILL && bus_req && bus_is_ram) begin
      bus_write_ok   = bus_we && (bus_addr < DLK_ROW_BYTES);
      bus_read_blank = !bus_we;
    end else begin
      bus_write_ok = bus_grant && bus_we;
    end
  end

endmodule // dlk_session

// >>> verif/dlk_session_assertions.sv
// Checker for the debug link session block, port-level timing relations.
// Assumes the design's single clock and async active-high reset.
`timescale 1ns/1ps
module dlk_session_chk
  import dlk_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       cs_wr,
  input wire logic       cs_rd,
  input wire logic [3:0] cs_addr,
  input wire logic [7:0] cs_wdata,
  input wire logic [7:0] cs_rdata,
  input wire logic       sync_edge,
  input wire logic       bus_req,
  input wire logic       bus_we,
  input wire logic       bus_is_ram,
  input wire logic       bus_grant,
  input wire logic       bus_read_blank,
  input wire logic       lock_bits_set,
  input wire logic       system_clock_on,
  input wire logic       erase_start,
  input wire logic       row_prog_start,
  input wire logic       sys_reset_req,
  input wire logic       brownout_detector_force,
  input wire logic       system_clock_request,
  input wire logic       sync_edge_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire rq_wr = cs_wr && cs_addr == DLK_REG_RST;

  chk_lock_refuse: assert property (bus_grant |-> bus_req && !lock_bits_set)
    else $error("bus granted while locked");
  chk_grant_open: assert property (bus_req && !lock_bits_set && system_clock_on |-> bus_grant)
    else $error("bus refused while open");
  chk_clock_off: assert property (bus_grant |-> system_clock_on || system_clock_request)
    else $error("bus granted with clock stopped");
  chk_row_blank: assert property (bus_read_blank |-> bus_req && !bus_we && bus_is_ram)
    else $error("blank read without ram read");
  chk_reset_set: assert property (rq_wr && cs_wdata == DLK_RST_ASSERT |=> ##[0:1] sys_reset_req)
    else $error("reset code did not assert reset");
  chk_reset_clr: assert property (rq_wr && cs_wdata == DLK_RST_RELEASE |=> ##1 !sys_reset_req)
    else $error("zero write did not release reset");
  chk_reset_hold: assert property (sys_reset_req && !rq_wr && !$past(cs_wr) |=> sys_reset_req)
    else $error("reset dropped without release");
  chk_event_rise: assert property ($rose(sync_edge) |=> sync_edge_event)
    else $error("sync edge gave no event");
  chk_bod_erase: assert property (erase_start |-> ##[0:1] brownout_detector_force)
    else $error("brownout not forced in erase");
  chk_rev_read: assert property (cs_rd && cs_addr == DLK_REG_REV |=> cs_rdata == DLK_REV_VALUE)
    else $error("revision read wrong");

  cov_erase: cover property (erase_start);
  cov_row: cover property (row_prog_start);
  cov_reset: cover property ($rose(sys_reset_req));
endmodule // dlk_session_chk

bind dlk_session dlk_session_chk dlk_session_chk_inst (.clk, .sys_rst, .cs_wr, .cs_rd, .cs_addr,
  .cs_wdata, .cs_rdata, .sync_edge, .bus_req, .bus_we, .bus_is_ram, .bus_grant, .bus_read_blank,
  .lock_bits_set, .system_clock_on, .erase_start, .row_prog_start, .sys_reset_req,
  .brownout_detector_force, .system_clock_request, .sync_edge_event);

// >>> verif/dlk_nvm_model.sv
// Nonvolatile controller stand-in: answers erase and row start after a delay.
// Assumes start pulses of one cycle; lock stays set on a failed erase.
`timescale 1ns/1ps
module dlk_nvm_model #(
  parameter int DELAY = 20
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic erase_start,
  input  wire logic row_prog_start,
  input  wire logic fail_mode,
  output logic      lock_bits_set,
  output logic      erase_done,
  output logic      erase_fail,
  output logic      row_prog_done
);
  int ecnt;
  int rcnt;
  assign erase_fail = fail_mode;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_bits_set <= 1'h1;
      ecnt <= 0;
      rcnt <= 0;
      erase_done <= 1'h0;
      row_prog_done <= 1'h0;
    end else begin
      erase_done <= ecnt == 1;
      row_prog_done <= rcnt == 1;
      ecnt <= erase_start ? DELAY : (ecnt > 0 ? ecnt - 1 : 0);
      rcnt <= row_prog_start ? DELAY : (rcnt > 0 ? rcnt - 1 : 0);
      // Lock only lifts on a clean erase
      if (ecnt == 1 && !fail_mode) lock_bits_set <= 1'h0;
    end
  end
endmodule // dlk_nvm_model

// >>> verif/tb_top.sv
// Testbench for the debug link session block: key sessions, reset, bus gating.
// Assumes the nonvolatile model answers within its delay parameter.
`timescale 1ns/1ps
module tb_top;
  import dlk_pkg::*;
  logic        clk = 1'h0, sys_rst = 1'h1, cs_wr = 1'h0, cs_rd = 1'h0, key_start = 1'h0;
  logic        key_byte_vld = 1'h0, sync_edge = 1'h0, link_err_set = 1'h0, bus_req = 1'h0;
  logic        bus_we = 1'h0, bus_is_ram = 1'h1, system_sleeping = 1'h0, system_clock_on = 1'h1;
  logic        boot_done = 1'h0, fail_mode = 1'h1, bod_seen = 1'h0;
  logic [3:0]  cs_addr = 4'h0;
  logic [7:0]  cs_wdata = 8'h00, key_byte = 8'h00, cs_rdata, link_phy_cfg;
  logic [2:0]  link_err_code = 3'h0, boot_check_code = 3'h0;
  logic [15:0] bus_addr = 16'h0000;
  logic [1:0]  link_clk_sel;
  logic        bus_grant, bus_write_ok, bus_read_blank, lock_bits_set, erase_done, erase_fail;
  logic        row_prog_done, sys_reset_req, erase_start, row_prog_start, link_disable;
  logic        brownout_detector_force, system_clock_request, sync_edge_event;
  int          fails = 0, total_checks = 0;

  always #20 clk = ~clk;
  always @(posedge clk) if (brownout_detector_force === 1'h1) bod_seen <= 1'h1;

  dlk_session dlk_session_inst (.clk, .sys_rst, .cs_wr, .cs_rd, .cs_addr, .cs_wdata, .cs_rdata,
    .key_start, .key_byte_vld, .key_byte, .sync_edge, .link_err_code, .link_err_set, .bus_req,
    .bus_we, .bus_addr, .bus_is_ram, .bus_grant, .bus_write_ok, .bus_read_blank, .lock_bits_set,
    .system_sleeping, .system_clock_on, .boot_done, .boot_check_code, .erase_done, .erase_fail,
    .row_prog_done, .sys_reset_req, .erase_start, .row_prog_start, .brownout_detector_force,
    .system_clock_request, .sync_edge_event, .link_phy_cfg, .link_clk_sel, .link_disable);

  dlk_nvm_model #(.DELAY(20)) dlk_nvm_model_inst (.clk, .sys_rst, .erase_start,
    .row_prog_start, .fail_mode, .lock_bits_set, .erase_done, .erase_fail, .row_prog_done);

  task automatic complete_run;
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) begin
      cs_wr <= 1'h1;
      cs_addr <= a;
      cs_wdata <= d;
    end
    @(posedge clk) cs_wr <= 1'h0;
  endtask

  task automatic rdq(input logic [3:0] a);
    @(posedge clk) begin
      cs_rd <= 1'h1;
      cs_addr <= a;
    end
    @(posedge clk) cs_rd <= 1'h0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rdq(a);
    chk(cs_rdata, e);
  endtask

  // Bounded poll, as the programmer does on status bits
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      rdq(DLK_REG_SYSSTAT);
      n++;
    end while (cs_rdata[b] !== v && n < 100);
    chk({7'h00, cs_rdata[b]}, {7'h00, v});
  endtask

  task automatic key(input logic [63:0] k);
    @(posedge clk) key_start <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) key_start <= 1'h0;
      key_byte_vld <= 1'h1;
      key_byte <= k[i*8 +: 8];
    end
    @(posedge clk) key_byte_vld <= 1'h0;
    repeat (2) @(posedge clk);
  endtask

  // Checks {grant, write ok, blank read} against e
  task automatic bus(input logic we, input logic [15:0] a, input logic [2:0] e);
    @(posedge clk) begin
      bus_req <= 1'h1;
      bus_we <= we;
      bus_addr <= a;
    end
    #1 chk({5'h00, bus_grant, bus_write_ok, bus_read_blank}, {5'h00, e});
    @(posedge clk) bus_req <= 1'h0;
  endtask

  task automatic rstcyc;
    wr(DLK_REG_RST, DLK_RST_ASSERT);
    wr(DLK_REG_RST, DLK_RST_RELEASE);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run;
  end

  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    rd(DLK_REG_REV, 8'h10);
    rd(DLK_REG_ERR, 8'h00);
    rd(DLK_REG_PHY, 8'h00);
    rd(DLK_REG_EN, 8'h00);
    rd(DLK_REG_KEY, 8'h00);
    rd(DLK_REG_RST, 8'h00);
    rd(DLK_REG_CLKDIV, 8'h03);
    rd(DLK_REG_SYSCTL, 8'h01);
    rd(DLK_REG_SYSSTAT, 8'h01);
    rd(4'h4, 8'h00);
    chk({7'h00, sys_reset_req}, 8'h00);
    // Failed erase first, device still locked
    key(DLK_KEY_ERASE);
    rd(DLK_REG_KEY, 8'h08);
    bus(1'h1, 16'h0000, 3'h0);
    wr(DLK_REG_RST, DLK_RST_ASSERT);
    wr(DLK_REG_RST, 8'h12);
    wr(DLK_REG_CLKDIV, 8'h01);
    #1 chk({7'h00, sys_reset_req}, 8'h01);
    chk({6'h00, link_clk_sel}, 8'h01);
    rd(DLK_REG_CLKDIV, 8'h01);
    wr(DLK_REG_RST, DLK_RST_RELEASE);
    @(posedge clk) #1 chk({7'h00, sys_reset_req}, 8'h00);
    repeat (40) @(posedge clk);
    rd(DLK_REG_SYSSTAT, 8'h41);
    rd(DLK_REG_KEY, 8'h00);
    chk({7'h00, bod_seen}, 8'h01);
    // Clean erase unlocks the bus
    fail_mode <= 1'h0;
    key(DLK_KEY_ERASE);
    rstcyc;
    poll(DLK_ST_LOCK_BIT, 1'h0);
    rd(DLK_REG_SYSSTAT, 8'h00);
    bus(1'h1, 16'h0100, 3'h6);
    // Programming session
    key(DLK_KEY_PROG);
    rd(DLK_REG_KEY, 8'h10);
    rstcyc;
    rd(DLK_REG_SYSSTAT, 8'h08);
    rd(DLK_REG_KEY, 8'h00);
    rstcyc;
    rd(DLK_REG_SYSSTAT, 8'h00);
    // User row session
    key(DLK_KEY_ROW);
    rd(DLK_REG_KEY, 8'h20);
    rstcyc;
    poll(DLK_ST_ROW_BIT, 1'h1);
    bus(1'h1, 16'h001F, 3'h6);
    bus(1'h1, 16'h0020, 3'h4);
    bus(1'h0, 16'h0005, 3'h5);
    wr(DLK_REG_SYSCTL, 8'h03);
    poll(DLK_ST_ROW_BIT, 1'h0);
    wr(DLK_REG_KEY, 8'h20);
    rd(DLK_REG_KEY, 8'h00);
    rstcyc;
    // Sleep with and without the clock request
    @(posedge clk) begin
      system_sleeping <= 1'h1;
      system_clock_on <= 1'h0;
    end
    bus(1'h1, 16'h0100, 3'h6);
    wr(DLK_REG_SYSCTL, 8'h00);
    #1 chk({7'h00, system_clock_request}, 8'h00);
    bus(1'h1, 16'h0100, 3'h0);
    rd(DLK_REG_SYSSTAT, 8'h10);
    @(posedge clk) sync_edge <= 1'h1;
    @(posedge clk) sync_edge <= 1'h0;
    #1 chk({7'h00, sync_edge_event}, 8'h01);
    @(posedge clk) begin
      link_err_set <= 1'h1;
      link_err_code <= 3'h6;
    end
    @(posedge clk) link_err_set <= 1'h0;
    rd(DLK_REG_ERR, 8'h06);
    rd(DLK_REG_ERR, 8'h00);
    // Link disable drops keys, settings and the clock request
    wr(DLK_REG_PHY, 8'h25);
    wr(DLK_REG_SYSCTL, 8'h01);
    key(DLK_KEY_ROW);
    #1 chk(link_phy_cfg, 8'h25);
    chk({7'h00, system_clock_request}, 8'h01);
    wr(DLK_REG_EN, 8'h04);
    @(posedge clk) #1 chk({7'h00, link_disable}, 8'h01);
    chk({link_clk_sel, link_phy_cfg[5:0]}, 8'hC0);
    chk({7'h00, system_clock_request}, 8'h00);
    rd(DLK_REG_KEY, 8'h00);
    complete_run;
  end
endmodule // tb_top
